/* bench/ssl_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Host side of the three-wire link; the serial clock runs only inside a frame
module ssl_host_model (
  // Link pins
  output logic sclk_o,
  output logic data_o,
  output logic strobe_o
);
  initial begin
    sclk_o   = 1'b0;
    data_o   = 1'b0;
    strobe_o = 1'b0;
  end

  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      data_o = word[i];
      #62;
      sclk_o = 1'b1;
      #63;
      sclk_o = 1'b0;
    end
    // Released data line shows the inverse of its last bit
    data_o = ~word[0];
    #200;
    strobe_o = 1'b1;
    #100;
    strobe_o = 1'b0;
    #200;
  endtask
endmodule

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import ssl_pkg::*;

  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sclk, sdata, strobe;
  logic chip_active_i = 1'b1;
  logic ref_tick_i = 1'b0;
  logic presc_tick_i = 1'b0;
  logic err_below_15_i = 1'b0;
  logic err_above_25_i = 1'b0;
  logic pump_event_i = 1'b0;
  logic ref_div_pulse_o, fb_div_pulse_o, modulus_high_o, pump_hiz_o, powered_down_o;
  logic lock_o, test_output_pin_o, detector_polarity_o, fast_gain_o;
  logic [1:0] backlash_width_o, test_mode_o, prescale_select_o;
  logic [2:0] pump_current_one_o, pump_current_two_o;
  int n_fail = 0;
  int compares = 0;
  int n_tp = 0;

  always #5 clock_i = ~clock_i;
  // Sampled mid-cycle so the registered test pin has settled
  always @(negedge clock_i) if (test_output_pin_o === 1'b1) n_tp++;

  ssl_host_model host (.sclk_o(sclk), .data_o(sdata), .strobe_o(strobe));

  ssl_core dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .sclk_i(sclk), .serial_data_i(sdata),
    .latch_strobe_i(strobe), .chip_active_i(chip_active_i), .ref_tick_i(ref_tick_i),
    .presc_tick_i(presc_tick_i), .err_below_15_i(err_below_15_i),
    .err_above_25_i(err_above_25_i), .pump_event_i(pump_event_i),
    .ref_div_pulse_o(ref_div_pulse_o), .fb_div_pulse_o(fb_div_pulse_o),
    .modulus_high_o(modulus_high_o), .pump_hiz_o(pump_hiz_o),
    .powered_down_o(powered_down_o), .lock_o(lock_o),
    .test_output_pin_o(test_output_pin_o), .backlash_width_o(backlash_width_o),
    .test_mode_o(test_mode_o), .prescale_select_o(prescale_select_o),
    .pump_current_one_o(pump_current_one_o), .pump_current_two_o(pump_current_two_o),
    .detector_polarity_o(detector_polarity_o), .fast_gain_o(fast_gain_o)
  );

  function automatic logic [23:0] fnw(logic [2:0] mux, logic arm, logic sync, logic clr,
                                      logic tri_b, logic [1:0] sel);
    return {2'h1, sync, 3'h5, 3'h3, 4'h0, 2'h0, tri_b, 1'b1, mux, arm, clr, sel};
  endfunction

  function automatic logic [23:0] refw(logic lock_precision_select, logic [1:0] abp, logic [13:0] r);
    return {3'h0, lock_precision_select, 2'h2, abp, r, 2'h0};
  endfunction

  function automatic logic [23:0] fbw(logic gain, logic [12:0] b, logic [5:0] a);
    return {2'h0, gain, b, a, 2'h1};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic count(input int cyc, output int nr, output int nf);
    nr = 0;
    nf = 0;
    repeat (cyc) begin
      @(negedge clock_i);
      nr += (ref_div_pulse_o === 1'b1);
      nf += (fb_div_pulse_o === 1'b1);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Latch routing, field placement and both dividers, with counter clear
  task automatic test_config();
    int nr, nf;
    host.send(refw(1'b0, 2'h2, 14'h3) | 24'h800000);
    host.send(fbw(1'b1, 13'h5, 6'h2));
    host.send(fnw(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2));
    waitc(2);
    check(backlash_width_o, 2'h2);
    check(test_mode_o, 2'h2);
    check({prescale_select_o, pump_current_two_o, pump_current_one_o}, 8'h6b);
    check({detector_polarity_o, fast_gain_o}, 2'h3);
    ref_tick_i = 1'b1;
    presc_tick_i = 1'b1;
    count(30, nr, nf);
    check(nr, 10);
    check(nf, 6);
    host.send(fnw(3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2));
    count(40, nr, nf);
    check({nr[7:0], nf[7:0]}, 16'h0);
    check(pump_hiz_o, 1'b1);
    check(modulus_high_o, 1'b1);
    host.send(fnw(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2));
    waitc(3);
    count(30, nr, nf);
    check({nr[7:0], nf[7:0]}, 16'h0a06);
    $display("test config done");
  endtask

  task automatic test_lock(input logic lock_precision_select, input int need);
    int n;
    host.send(refw(lock_precision_select, 2'h1, 14'h4));
    @(negedge clock_i);
    err_below_15_i = 1'b0;
    err_above_25_i = 1'b1;
    waitc(20);
    check(lock_o, 1'b0);
    while (ref_div_pulse_o !== 1'b1) @(negedge clock_i);
    waitc(2);
    err_below_15_i = 1'b1;
    err_above_25_i = 1'b0;
    n = 0;
    repeat (60) begin
      @(negedge clock_i);
      if (lock_o !== 1'b1) n += (ref_div_pulse_o === 1'b1);
    end
    check(n, need);
    err_below_15_i = 1'b0;
    waitc(24);
    check(lock_o, 1'b1);
    err_above_25_i = 1'b1;
    waitc(10);
    check(lock_o, 1'b0);
    $display("test lock done");
  endtask

  task automatic test_powerdown();
    int nr, nf;
    err_below_15_i = 1'b1;
    err_above_25_i = 1'b0;
    waitc(40);
    check(lock_o, 1'b1);
    chip_active_i = 1'b0;
    waitc(8);
    check({powered_down_o, pump_hiz_o, lock_o}, 3'h6);
    count(20, nr, nf);
    check({nr[7:0], nf[7:0]}, 16'h0);
    host.send(refw(1'b1, 2'h3, 14'h4));
    host.send(fnw(3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2));
    waitc(2);
    check({backlash_width_o, test_output_pin_o}, 3'h7);
    chip_active_i = 1'b1;
    waitc(8);
    check({powered_down_o, test_output_pin_o}, 2'h0);
    host.send(fnw(3'h4, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2));
    check({powered_down_o, pump_hiz_o, lock_o}, 3'h6);
    host.send(fnw(3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2));
    host.send(fnw(3'h4, 1'b1, 1'b1, 1'b0, 1'b0, 2'h2));
    waitc(10);
    check(powered_down_o, 1'b0);
    pump_event_i = 1'b1;
    @(negedge clock_i);
    pump_event_i = 1'b0;
    waitc(2);
    check(powered_down_o, 1'b1);
    host.send(fnw(3'h4, 1'b0, 1'b0, 1'b0, 1'b1, 2'h2));
    check({powered_down_o, pump_hiz_o}, 2'h1);
    host.send(fnw(3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2));
    check(pump_hiz_o, 1'b0);
    $display("test powerdown done");
  endtask

  // Internal reset pulse seen on the test pin: first feedback load after init, not the second
  task automatic test_init();
    host.send(fnw(3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 2'h3));
    n_tp = 0;
    host.send(fbw(1'b0, 13'h5, 6'h2));
    check(n_tp != 0, 1'b1);
    n_tp = 0;
    host.send(fbw(1'b0, 13'h6, 6'h1));
    check(n_tp, 0);
    $display("test init done");
  endtask

  initial begin
    waitc(6);
    rstn_i = 1'b1;
    waitc(10);
    test_config();
    test_lock(1'b0, 3);
    test_lock(1'b1, 5);
    test_powerdown();
    test_init();
    give_verdict();
  end

  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule

`default_nettype wire

/* rtl/ssl_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ssl_defs.svh"

module ssl_core
  import ssl_pkg::*;
(
  // System clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Three-wire link and chip active pin
  input  wire logic       sclk_i,
  input  wire logic       serial_data_i,
  input  wire logic       latch_strobe_i,
  input  wire logic       chip_active_i,
  // Divider clock ticks and detector inputs
  input  wire logic       ref_tick_i,
  input  wire logic       presc_tick_i,
  input  wire logic       err_below_15_i,
  input  wire logic       err_above_25_i,
  input  wire logic       pump_event_i,
  // Divider and detector outputs
  output logic            ref_div_pulse_o,
  output logic            fb_div_pulse_o,
  output logic            modulus_high_o,
  output logic            pump_hiz_o,
  output logic            powered_down_o,
  output logic            lock_o,
  output logic            test_output_pin_o,
  // Configuration fields toward the analog section
  output logic      [1:0] backlash_width_o,
  output logic      [1:0] test_mode_o,
  output logic      [1:0] prescale_select_o,
  output logic      [2:0] pump_current_one_o,
  output logic      [2:0] pump_current_two_o,
  output logic            detector_polarity_o,
  output logic            fast_gain_o
);

  ssl_core_s              q;
  ssl_core_s              d;
  logic [`SSL_WORD_W-1:0] link_word;
  ssl_target_e            target;
  logic                   strobe_stable;
  logic                   active_stable;
  logic                   commit;
  logic                   hold;
  logic                   pd;
  logic [13:0]            ref_val;
  logic [5:0]             a_val;
  logic [12:0]            b_val;
  logic [2:0]             lock_need;
  logic [8:0]             tmo_limit;
  logic                   fastlock_run;
  logic [7:0]             mux_src;

  ssl_serial_shift u_shift (
    .sclk_i        (sclk_i),
    .rstn_i        (rstn_i),
    .serial_data_i (serial_data_i),
    .word_o        (link_word)
  );

  // The host lets the serial clock stand once the strobe rises, so the
  // word is stable when the synchronised edge samples it
  assign target        = ssl_target_e'(link_word[`SSL_SEL_MSB:`SSL_SEL_LSB]);
  assign strobe_stable = (q.strobe_s[1] == q.strobe_s[2]);
  assign active_stable = (q.active_s[1] == q.active_s[2]);
  assign commit        = strobe_stable && q.strobe_s[2] && !q.strobe_lvl;

  assign ref_val = q.ref_word[`SSL_REF_DIV_MSB:`SSL_REF_DIV_LSB];
  assign a_val   = q.fb_word[`SSL_FB_A_MSB:`SSL_FB_A_LSB];
  assign b_val   = q.fb_word[`SSL_FB_B_MSB:`SSL_FB_B_LSB];

  // Pin low wins over anything programmed
  assign pd   = !q.active_lvl || q.prog_pd;
  assign hold = q.fn_word[`SSL_FN_CLEAR] || pd || q.init_pulse;

  assign lock_need = q.ref_word[`SSL_REF_LDP] ? `SSL_LOCK_FINE : `SSL_LOCK_COARSE;
  assign tmo_limit = 9'(({5'h00, q.fn_word[`SSL_FN_TC_MSB:`SSL_FN_TC_LSB]} + 9'h001)
                     << `SSL_TMO_SHIFT);
  assign fastlock_run = q.fn_word[`SSL_FN_FL_EN] && q.fn_word[`SSL_FN_FL_MODE]
                        && q.fb_word[`SSL_FB_GAIN];

  // Test output sources
  assign mux_src = {q.init_pulse, pump_hiz_o, modulus_high_o, pd,
                    q.fb_pulse, q.ref_pulse, q.locked, 1'b0};

  always_comb begin
    d = q;
    d.strobe_s   = {q.strobe_s[1:0], latch_strobe_i};
    d.active_s   = {q.active_s[1:0], chip_active_i};
    if (strobe_stable) begin
      d.strobe_lvl = q.strobe_s[2];
    end
    if (active_stable) begin
      d.active_lvl = q.active_s[2];
    end
    d.init_pulse = 1'b0;
    d.ref_pulse  = 1'b0;
    d.fb_pulse   = 1'b0;

    // Fastlock timeout, counted in detector cycles
    if (hold || !fastlock_run) begin
      d.tmo_cnt = '0;
    end else if (q.ref_pulse) begin
      if (9'(q.tmo_cnt + 9'h001) >= tmo_limit) begin
        d.tmo_cnt = '0;
        d.fb_word[`SSL_FB_GAIN] = 1'b0;
      end else begin
        d.tmo_cnt = 9'(q.tmo_cnt + 9'h001);
      end
    end

    // Latch transfer; works in every power state, reserved bits unused
    if (commit) begin
      case (target)
        ssl_sel_ref: begin
          d.ref_word = link_word;
        end
        ssl_sel_fb: begin
          d.fb_word = link_word;
          if (q.init_pend) begin
            d.init_pulse = 1'b1;
            d.init_pend  = 1'b0;
          end
        end
        ssl_sel_func: begin
          d.fn_word = link_word;
        end
        ssl_sel_init: begin
          d.fn_word    = link_word;
          d.init_pulse = 1'b1;
          d.init_pend  = 1'b1;
        end
        default: begin
          d.fn_word = q.fn_word;
        end
      endcase
    end

    // Programmed power-down, only while the chip active pin enables it
    if (!q.active_lvl || !q.fn_word[`SSL_FN_PD_ARM]) begin
      d.prog_pd = 1'b0;
    end else if (!q.fn_word[`SSL_FN_PD_SYNC]) begin
      d.prog_pd = 1'b1;
    end else if (pump_event_i) begin
      d.prog_pd = 1'b1;
    end

    // Reference divider
    if (hold) begin
      d.ref_cnt = ref_val;
    end else if (ref_tick_i) begin
      if (q.ref_cnt <= 14'h0001) begin
        d.ref_cnt   = ref_val;
        d.ref_pulse = 1'b1;
      end else begin
        d.ref_cnt = 14'(q.ref_cnt - 14'h0001);
      end
    end

    // Feedback divider: swallow count runs the prescaler at P+1
    if (hold) begin
      d.a_cnt = a_val;
      d.b_cnt = b_val;
    end else if (presc_tick_i) begin
      if (q.b_cnt <= 13'h0001) begin
        d.a_cnt    = a_val;
        d.b_cnt    = b_val;
        d.fb_pulse = 1'b1;
      end else begin
        d.b_cnt = 13'(q.b_cnt - 13'h0001);
        if (q.a_cnt != 6'h00) begin
          d.a_cnt = 6'(q.a_cnt - 6'h01);
        end
      end
    end

    // Digital lock detection, one step per detector cycle
    if (pd) begin
      d.locked   = 1'b0;
      d.lock_cnt = '0;
    end else if (q.ref_pulse) begin
      if (q.locked) begin
        if (err_above_25_i) begin
          d.locked   = 1'b0;
          d.lock_cnt = '0;
        end
      end else if (err_below_15_i) begin
        d.lock_cnt = 3'(q.lock_cnt + 3'h1);
        if (3'(q.lock_cnt + 3'h1) >= lock_need) begin
          d.locked = 1'b1;
        end
      end else begin
        d.lock_cnt = '0;
      end
    end

    d.test_out = mux_src[q.fn_word[`SSL_FN_MUX_MSB:`SSL_FN_MUX_LSB]];
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q          <= '0;
      q.ref_word <= `SSL_RST_REF_WORD;
      q.fb_word  <= `SSL_RST_FB_WORD;
      q.fn_word  <= `SSL_RST_FN_WORD;
    end else begin
      q <= d;
    end
  end

  // Pump is three-stated in power-down, by the tristate bit, and while held
  assign pump_hiz_o          = pd || hold || q.fn_word[`SSL_FN_TRI];
  assign powered_down_o      = pd;
  assign ref_div_pulse_o     = q.ref_pulse;
  assign fb_div_pulse_o      = q.fb_pulse;
  assign modulus_high_o      = (q.a_cnt != 6'h00);
  assign lock_o              = q.locked;
  assign test_output_pin_o   = q.test_out;
  assign backlash_width_o    = q.ref_word[`SSL_REF_ABP_MSB:`SSL_REF_ABP_LSB];
  assign test_mode_o         = q.ref_word[`SSL_REF_TM_MSB:`SSL_REF_TM_LSB];
  assign prescale_select_o   = q.fn_word[`SSL_FN_PS_MSB:`SSL_FN_PS_LSB];
  assign pump_current_one_o  = q.fn_word[`SSL_FN_CP1_MSB:`SSL_FN_CP1_LSB];
  assign pump_current_two_o  = q.fn_word[`SSL_FN_CP2_MSB:`SSL_FN_CP2_LSB];
  assign detector_polarity_o = q.fn_word[`SSL_FN_POL];
  assign fast_gain_o         = q.fb_word[`SSL_FB_GAIN];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_commit_init;
    commit && (target == ssl_sel_init);
  endsequence

  sequence s_one_pulse;
    q.init_pulse ##1 !q.init_pulse;
  endsequence

  chk_ref_latch_load: assert property (
    commit && (target == ssl_sel_ref) |=> q.ref_word == $past(link_word))
    else $error("reference word not loaded on strobe");

  chk_fb_latch_load: assert property (
    commit && (target == ssl_sel_fb) |=> q.fb_word == $past(link_word)
                                         && $stable(q.fn_word))
    else $error("feedback word not loaded on strobe");

  chk_init_pulse: assert property (
    s_commit_init |=> (q.fn_word == $past(link_word)) and s_one_pulse)
    else $error("init write did not load config and pulse once");

  chk_first_fb_pulse: assert property (
    commit && (target == ssl_sel_fb) |=> q.init_pulse == $past(q.init_pend))
    else $error("feedback load pulse wrong after init");

  chk_coarse_lock: assert property (
    $rose(q.locked) && !q.ref_word[`SSL_REF_LDP] |-> $past(q.lock_cnt) == 3'h2)
    else $error("coarse lock set after wrong cycle count");

  chk_fine_lock: assert property (
    $rose(q.locked) && q.ref_word[`SSL_REF_LDP] |-> $past(q.lock_cnt) == 3'h4)
    else $error("fine lock set after wrong cycle count");

  chk_lock_hold: assert property (
    q.locked && !pd && !(q.ref_pulse && err_above_25_i) |=> q.locked)
    else $error("lock dropped without large error");

  chk_pd_lock_clear: assert property (
    pd |=> !q.locked && (q.lock_cnt == 3'h0))
    else $error("lock state survived power-down");

  chk_clear_holds: assert property (
    q.fn_word[`SSL_FN_CLEAR] |=> (q.ref_cnt == $past(ref_val)) && (q.b_cnt == $past(b_val)))
    else $error("dividers ran during counter clear");

  chk_pin_down: assert property (
    !q.active_lvl |-> powered_down_o && pump_hiz_o)
    else $error("chip active low but not powered down");

  chk_async_pd: assert property (
    q.active_lvl && q.fn_word[`SSL_FN_PD_ARM] && !q.fn_word[`SSL_FN_PD_SYNC]
    |=> q.prog_pd || !q.active_lvl)
    else $error("async power-down not immediate");

  chk_sync_pd: assert property (
    $rose(q.prog_pd) && $past(q.fn_word[`SSL_FN_PD_SYNC]) |-> $past(pump_event_i))
    else $error("sync power-down without pump event");

endmodule

`default_nettype wire

/* rtl/ssl_defs.svh */
`ifndef SSL_DEFS_SVH
`define SSL_DEFS_SVH

// Serial word
`define SSL_WORD_W          24
`define SSL_SEL_MSB         1
`define SSL_SEL_LSB         0

// Reference divider word fields
`define SSL_REF_DIV_MSB     15
`define SSL_REF_DIV_LSB     2
`define SSL_REF_ABP_MSB     17
`define SSL_REF_ABP_LSB     16
`define SSL_REF_TM_MSB      19
`define SSL_REF_TM_LSB      18
`define SSL_REF_LDP         20

// Feedback divider word fields
`define SSL_FB_A_MSB        7
`define SSL_FB_A_LSB        2
`define SSL_FB_B_MSB        20
`define SSL_FB_B_LSB        8
`define SSL_FB_GAIN         21

// Operating / startup config word fields
`define SSL_FN_CLEAR        2
`define SSL_FN_PD_ARM       3
`define SSL_FN_MUX_MSB      6
`define SSL_FN_MUX_LSB      4
`define SSL_FN_POL          7
`define SSL_FN_TRI          8
`define SSL_FN_FL_EN        9
`define SSL_FN_FL_MODE      10
`define SSL_FN_TC_MSB       14
`define SSL_FN_TC_LSB       11
`define SSL_FN_CP1_MSB      17
`define SSL_FN_CP1_LSB      15
`define SSL_FN_CP2_MSB      20
`define SSL_FN_CP2_LSB      18
`define SSL_FN_PD_SYNC      21
`define SSL_FN_PS_MSB       23
`define SSL_FN_PS_LSB       22

// Reset values of the latches
`define SSL_RST_REF_WORD    24'h000004
`define SSL_RST_FB_WORD     24'h000301
`define SSL_RST_FN_WORD     24'h000002

// Lock detection: consecutive good detector cycles needed
`define SSL_LOCK_COARSE     3'h3
`define SSL_LOCK_FINE       3'h5

// Fastlock timeout: detector cycles per timeout step, as a shift
`define SSL_TMO_SHIFT       4

`endif

/* rtl/ssl_pkg.sv */
`include "ssl_defs.svh"

package ssl_pkg;

  typedef enum logic [1:0] {
    ssl_sel_ref  = 2'h0,
    ssl_sel_fb   = 2'h1,
    ssl_sel_func = 2'h2,
    ssl_sel_init = 2'h3
  } ssl_target_e;

  typedef struct packed {
    logic [`SSL_WORD_W-1:0] shift;
  } ssl_link_s;

  typedef struct packed {
    logic [2:0]             strobe_s;
    logic [2:0]             active_s;
    logic                   strobe_lvl;
    logic                   active_lvl;
    logic [`SSL_WORD_W-1:0] ref_word;
    logic [`SSL_WORD_W-1:0] fb_word;
    logic [`SSL_WORD_W-1:0] fn_word;
    logic                   init_pend;
    logic                   init_pulse;
    logic                   prog_pd;
    logic [13:0]            ref_cnt;
    logic [5:0]             a_cnt;
    logic [12:0]            b_cnt;
    logic                   ref_pulse;
    logic                   fb_pulse;
    logic [2:0]             lock_cnt;
    logic                   locked;
    logic [8:0]             tmo_cnt;
    logic                   test_out;
  } ssl_core_s;

endpackage

/* rtl/ssl_serial_shift.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ssl_defs.svh"

// Link-side input shift register, clocked by the serial clock
module ssl_serial_shift
  import ssl_pkg::*;
(
  // Link clock and reset
  input  wire logic                   sclk_i,
  input  wire logic                   rstn_i,
  // Serial data
  input  wire logic                   serial_data_i,
  // Assembled word, stable while the serial clock stands
  output logic      [`SSL_WORD_W-1:0] word_o
);

  ssl_link_s q;
  ssl_link_s d;

  always_comb begin
    d = q;
    // MSB first: each new bit enters at the bottom
    d.shift = {q.shift[`SSL_WORD_W-2:0], serial_data_i};
  end

  // Keeps shifting whatever the power-down state
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign word_o = q.shift;

endmodule

`default_nettype wire
